// ---- strap_pkg.sv ----
// constants and register map shared by the boot strap latch design
// What this block does
// RL1: every system reset, whatever its cause, latches the level of each strap pin as one bit.
// RL2: latched bits hold until power-down, whatever the strap pins do later.
// RL3: software reads all five latched bits from a read-only strap capture register.
// RL4: during reset each strap pin has its weak internal pull on, so an open pin latches the default.
// RL5: after reset release every strap pin goes back to its normal function.
// RL6: supply strap (default low) selects 3.3V for the flash rail when 0 and 1.8V when 1.
// RL7: boot select 1 means flash boot; boot select 0 with qualify 0 means download boot.
// RL8: log-and-timing strap 1 lets boot debug toggle the console line, 0 keeps it silent.
// RL9: slave sdio sampling edge comes from log-and-timing, output edge from the output-edge strap.
// RL10: after boot firmware can override the supply choice and the slave sdio edges.
// RL11: the board or a host drives a strap to a non-default level during power-up.
// RL12: chip enable is active high; the chip runs only while it is high.
// RL13: the bit order of the five straps in the capture register is fixed by this design.
package strap_pkg;
  localparam int STRAP_W = 5;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // capture register bit positions
  localparam int B_SUPPLY = 0;
  localparam int B_BOOT_SEL = 1;
  localparam int B_QUALIFY = 2;
  localparam int B_LOG_TIMING = 3;
  localparam int B_OUT_EDGE = 4;

  // default pull of each strap pin
  localparam logic [STRAP_W-1:0] PULL_UP_MASK = 5'h1a;
  localparam logic [STRAP_W-1:0] PULL_DOWN_MASK = 5'h05;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CAPTURE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OVERRIDE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

  // override register fields
  localparam int OV_SUPPLY_EN = 0;
  localparam int OV_SUPPLY_1V8 = 1;
  localparam int OV_SDIO_EN = 2;
  localparam int OV_SAMPLE_RISE = 3;
  localparam int OV_OUTPUT_RISE = 4;
  localparam int OV_W = 5;

  // status register fields
  localparam int ST_SUPPLY_1V8 = 0;
  localparam int ST_BOOT_FLASH = 1;
  localparam int ST_BOOT_DOWNLOAD = 2;
  localparam int ST_BOOT_INVALID = 3;
  localparam int ST_LOG_ENABLE = 4;
  localparam int ST_SAMPLE_RISE = 5;
  localparam int ST_OUTPUT_RISE = 6;
  localparam int ST_PINS_FUNC = 7;
  localparam int ST_PIN_DIFF = 8;
  localparam int ST_W = 9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    PH_SAMPLE = 3'h1,
    PH_OFF = 3'h2,
    PH_RUN = 3'h4
  } phase_t;
endpackage : strap_pkg

// ---- strap_pin_sync.sv ----
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module strap_pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic aclk,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } sync_t;

  sync_t sync_reg;
  sync_t sync_next;

  // no reset: the chain must keep sampling while reset is held
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = pin_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (sync_reg.s2[i] == sync_reg.s3[i]) begin
        sync_next.filt[i] = sync_reg.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    sync_reg <= sync_next;
  end

  assign pin_out = sync_reg.filt;
endmodule : strap_pin_sync

// ---- strap_axil_slave.sv ----
// axi4-lite slave front end with a simple register port
`timescale 1ns/1ps
module strap_axil_slave
  import strap_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [DATA_W/8-1:0] wr_strb,
  input wire logic [1:0] wr_resp,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [1:0] rd_resp
);
  typedef struct packed {
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W/8-1:0] strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axil_t;

  axil_t bus_reg;
  axil_t bus_next;

  assign wr_en = bus_reg.aw_held & bus_reg.w_held & ~bus_reg.bvalid;
  assign wr_addr = bus_reg.addr;
  assign wr_data = bus_reg.data;
  assign wr_strb = bus_reg.strb;
  assign rd_en = s_axi_arvalid & bus_reg.arready;
  assign rd_addr = s_axi_araddr;

  always_comb begin
    bus_next = bus_reg;
    if (s_axi_awvalid && bus_reg.awready) begin
      bus_next.aw_held = 1'b1;
      bus_next.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && bus_reg.wready) begin
      bus_next.w_held = 1'b1;
      bus_next.data = s_axi_wdata;
      bus_next.strb = s_axi_wstrb;
    end
    if (wr_en) begin
      bus_next.aw_held = 1'b0;
      bus_next.w_held = 1'b0;
      bus_next.bvalid = 1'b1;
      bus_next.bresp = wr_resp;
    end else if (bus_reg.bvalid && s_axi_bready) begin
      bus_next.bvalid = 1'b0;
    end
    // each channel takes one beat, then waits for the response to drain
    bus_next.awready = ~bus_next.aw_held & ~bus_next.bvalid;
    bus_next.wready = ~bus_next.w_held & ~bus_next.bvalid;
    if (rd_en) begin
      bus_next.rvalid = 1'b1;
      bus_next.rdata = rd_data;
      bus_next.rresp = rd_resp;
    end else if (bus_reg.rvalid && s_axi_rready) begin
      bus_next.rvalid = 1'b0;
    end
    bus_next.arready = ~bus_next.rvalid;
    if (!aresetn) begin
      bus_next = '0;
    end
  end

  always_ff @(posedge aclk) begin
    bus_reg <= bus_next;
  end

  assign s_axi_awready = bus_reg.awready;
  assign s_axi_wready = bus_reg.wready;
  assign s_axi_bvalid = bus_reg.bvalid;
  assign s_axi_bresp = bus_reg.bresp;
  assign s_axi_arready = bus_reg.arready;
  assign s_axi_rvalid = bus_reg.rvalid;
  assign s_axi_rdata = bus_reg.rdata;
  assign s_axi_rresp = bus_reg.rresp;
endmodule : strap_axil_slave

// ---- boot_strap_latch.sv ----
// boot strap latch: capture, hold and decode of the five straps, with override of the supply choice and sdio edges
`timescale 1ns/1ps
module boot_strap_latch
  import strap_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_enable,
  input wire logic supply_voltage_strap,
  input wire logic boot_select_strap,
  input wire logic download_qualify_strap,
  input wire logic log_and_timing_strap,
  input wire logic sdio_output_edge_strap,
  output logic [STRAP_W-1:0] strap_pull_up_en,
  output logic [STRAP_W-1:0] strap_pull_down_en,
  output logic strap_pins_functional,
  output logic chip_active,
  output logic flash_supply_1v8,
  output logic boot_from_flash,
  output logic boot_download,
  output logic boot_select_invalid,
  output logic boot_log_enable,
  output logic sdio_sample_rising,
  output logic sdio_output_rising,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    phase_t phase;
    logic [STRAP_W-1:0] pull_up;
    logic [STRAP_W-1:0] pull_down;
    logic pins_func;
    logic [STRAP_W-1:0] capture;
    logic [OV_W-1:0] ovr;
    logic pin_diff;
    logic active;
    logic supply_1v8;
    logic from_flash;
    logic download;
    logic invalid;
    logic log_en;
    logic sample_rise;
    logic output_rise;
  } latch_t;

  latch_t st_reg;
  latch_t st_next;

  logic [STRAP_W:0] pins_raw;
  logic [STRAP_W:0] pins_sync;
  logic [STRAP_W-1:0] strap_now;
  logic enable_now;

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W/8-1:0] wr_strb;
  logic [1:0] wr_resp;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic [1:0] rd_resp;

  // capture order of the straps
  assign pins_raw = {chip_enable, sdio_output_edge_strap, log_and_timing_strap,
                     download_qualify_strap, boot_select_strap, supply_voltage_strap}; // RL13

  strap_pin_sync #(
    .WIDTH(STRAP_W + 1)
  ) u_sync (
    .aclk(aclk),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  assign strap_now = pins_sync[STRAP_W-1:0];
  assign enable_now = pins_sync[STRAP_W];

  strap_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_resp(wr_resp),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_resp(rd_resp)
  );

  // answer code for an access to a given offset
  function automatic logic [1:0] access_resp(input logic [ADDR_W-1:0] addr,
                                             input logic is_write);
    logic [1:0] resp;
    resp = RESP_DECERR;
    case (addr)
      OFS_CAPTURE: begin
        resp = is_write ? RESP_SLVERR : RESP_OKAY; // RL3
      end
      OFS_OVERRIDE: begin
        resp = RESP_OKAY;
      end
      OFS_STATUS: begin
        resp = is_write ? RESP_SLVERR : RESP_OKAY;
      end
      default: begin
        resp = RESP_DECERR;
      end
    endcase
    return resp;
  endfunction : access_resp

  // status word of the current decoded state
  function automatic logic [ST_W-1:0] status_word(input latch_t s);
    logic [ST_W-1:0] w;
    w = '0;
    w[ST_SUPPLY_1V8] = s.supply_1v8;
    w[ST_BOOT_FLASH] = s.from_flash;
    w[ST_BOOT_DOWNLOAD] = s.download;
    w[ST_BOOT_INVALID] = s.invalid;
    w[ST_LOG_ENABLE] = s.log_en;
    w[ST_SAMPLE_RISE] = s.sample_rise;
    w[ST_OUTPUT_RISE] = s.output_rise;
    w[ST_PINS_FUNC] = s.pins_func;
    w[ST_PIN_DIFF] = s.pin_diff;
    return w;
  endfunction : status_word

  // firmware value wins over the strap once its enable bit is set
  function automatic logic pick_override(input logic ovr_en, input logic ovr_val,
                                         input logic strap_val);
    return ovr_en ? ovr_val : strap_val;
  endfunction : pick_override

  assign wr_resp = access_resp(wr_addr, 1'b1);
  assign rd_resp = access_resp(rd_addr, 1'b0);

  always_comb begin
    rd_data = '0;
    case (rd_addr)
      OFS_CAPTURE: begin
        rd_data[STRAP_W-1:0] = st_reg.capture; // RL3
      end
      OFS_OVERRIDE: begin
        rd_data[OV_W-1:0] = st_reg.ovr;
      end
      OFS_STATUS: begin
        rd_data[ST_W-1:0] = status_word(st_reg);
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (!aresetn || !enable_now) begin
      // reset or chip disabled: pulls on, pins owned by the latch, keep sampling
      st_next.phase = (!aresetn) ? PH_SAMPLE : PH_OFF; // RL12
      st_next.pull_up = PULL_UP_MASK; // RL4
      st_next.pull_down = PULL_DOWN_MASK; // RL4
      st_next.pins_func = 1'b0;
      st_next.capture = strap_now; // RL1
      st_next.ovr = '0;
      st_next.pin_diff = 1'b0;
      st_next.active = 1'b0; // RL12
      st_next.supply_1v8 = 1'b0;
      st_next.from_flash = 1'b0;
      st_next.download = 1'b0;
      st_next.invalid = 1'b0;
      st_next.log_en = 1'b0;
      st_next.sample_rise = 1'b0;
      st_next.output_rise = 1'b0;
    end else begin
      case (st_reg.phase)
        PH_SAMPLE, PH_OFF: begin
          // the last value sampled before release is the one kept
          st_next.phase = PH_RUN;
          st_next.pull_up = '0; // RL5
          st_next.pull_down = '0; // RL5
          st_next.pins_func = 1'b1; // RL5
          st_next.active = 1'b1;
        end
        PH_RUN: begin
          // capture is left alone here, so later pin activity has no effect
          st_next.capture = st_reg.capture; // RL2
          if (wr_en && wr_addr == OFS_OVERRIDE && wr_strb[0]) begin
            st_next.ovr = wr_data[OV_W-1:0]; // RL10
          end
          // sticky hint that a pin now differs from its captured level
          if (strap_now != st_reg.capture) begin
            st_next.pin_diff = 1'b1;
          end
        end
        default: begin
          st_next.phase = PH_SAMPLE;
        end
      endcase
      if (st_reg.phase == PH_RUN) begin
        st_next.supply_1v8 = pick_override(st_reg.ovr[OV_SUPPLY_EN], st_reg.ovr[OV_SUPPLY_1V8],
                                           st_reg.capture[B_SUPPLY]); // RL6 RL10
        st_next.from_flash = st_reg.capture[B_BOOT_SEL]; // RL7
        st_next.download = ~st_reg.capture[B_BOOT_SEL]
                           & ~st_reg.capture[B_QUALIFY]; // RL7
        // boot select low with qualify high is not a defined boot mode
        st_next.invalid = ~st_reg.capture[B_BOOT_SEL] & st_reg.capture[B_QUALIFY];
        st_next.log_en = st_reg.capture[B_LOG_TIMING]; // RL8
        st_next.sample_rise = pick_override(st_reg.ovr[OV_SDIO_EN], st_reg.ovr[OV_SAMPLE_RISE],
                                            st_reg.capture[B_LOG_TIMING]); // RL9 RL10
        st_next.output_rise = pick_override(st_reg.ovr[OV_SDIO_EN], st_reg.ovr[OV_OUTPUT_RISE],
                                            st_reg.capture[B_OUT_EDGE]); // RL9 RL10
      end
    end
  end

  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  assign strap_pull_up_en = st_reg.pull_up;
  assign strap_pull_down_en = st_reg.pull_down;
  assign strap_pins_functional = st_reg.pins_func;
  assign chip_active = st_reg.active;
  assign flash_supply_1v8 = st_reg.supply_1v8;
  assign boot_from_flash = st_reg.from_flash;
  assign boot_download = st_reg.download;
  assign boot_select_invalid = st_reg.invalid;
  assign boot_log_enable = st_reg.log_en;
  assign sdio_sample_rising = st_reg.sample_rise;
  assign sdio_output_rising = st_reg.output_rise;
endmodule : boot_strap_latch

// ---- strap_board_model.sv ----
// board side of the strap pins: resistors or host gpio, plus internal pulls
`timescale 1ns/1ps
module strap_board_model
  import strap_pkg::*;
(
  input wire logic aclk,
  input wire logic [STRAP_W-1:0] drive_en,
  input wire logic [STRAP_W-1:0] drive_val,
  input wire logic [STRAP_W-1:0] strap_pull_up_en,
  input wire logic [STRAP_W-1:0] strap_pull_down_en,
  output logic [STRAP_W-1:0] straps
);
  // undriven, unpulled pins wander so a late capture cannot pass by luck
  logic [STRAP_W-1:0] wander_reg = 5'h00;
  always_ff @(posedge aclk) begin
    wander_reg <= ~wander_reg;
  end
  always_comb begin
    for (int i = 0; i < STRAP_W; i++) begin
      if (drive_en[i]) begin
        straps[i] = drive_val[i];
      end else if (strap_pull_up_en[i]) begin
        straps[i] = 1'b1;
      end else if (strap_pull_down_en[i]) begin
        straps[i] = 1'b0;
      end else begin
        straps[i] = wander_reg[i];
      end
    end
  end
endmodule : strap_board_model

// ---- boot_strap_latch_monitor.sv ----
// concurrent checks on the boot strap latch ports
`timescale 1ns/1ps
module boot_strap_latch_monitor
  import strap_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_enable,
  input wire logic [STRAP_W-1:0] strap_pull_up_en,
  input wire logic [STRAP_W-1:0] strap_pull_down_en,
  input wire logic strap_pins_functional,
  input wire logic chip_active,
  input wire logic boot_from_flash,
  input wire logic boot_download,
  input wire logic boot_select_invalid,
  input wire logic boot_log_enable,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset itself is the cause here, so it cannot disable the check
  property p_reset_pulls;
    disable iff (1'b0) !aresetn |=> strap_pull_up_en == PULL_UP_MASK
      && strap_pull_down_en == PULL_DOWN_MASK;
  endproperty
  a_reset_pulls: assert property (p_reset_pulls) else $error("pulls wrong in reset");
  property p_release;
    $rose(aresetn) ##1 chip_active |-> strap_pins_functional && strap_pull_up_en == 5'h00;
  endproperty
  a_release: assert property (p_release) else $error("pins not released");
  property p_func_no_pull;
    strap_pins_functional |-> strap_pull_up_en == 5'h00 && strap_pull_down_en == 5'h00;
  endproperty
  a_func_no_pull: assert property (p_func_no_pull) else $error("pull left on");
  property p_hold;
    chip_active [*3] |-> $stable(boot_from_flash) && $stable(boot_download)
      && $stable(boot_log_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("latched setting moved");
  property p_onehot;
    chip_active [*2] |-> $onehot({boot_from_flash, boot_download, boot_select_invalid});
  endproperty
  a_onehot: assert property (p_onehot) else $error("boot mode not one-hot");
  property p_disable;
    !chip_enable [*8] |-> !chip_active;
  endproperty
  a_disable: assert property (p_disable) else $error("active while disabled");
  property p_off_quiet;
    !chip_active [*2] |-> !boot_from_flash && !boot_download && !boot_log_enable;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("decode while off");
  property p_read;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_read_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("read taken while busy");
  c_start: cover property ($rose(chip_active));
  c_read: cover property (s_axi_rvalid);
  c_off: cover property ($fell(chip_enable));
endmodule : boot_strap_latch_monitor

bind boot_strap_latch boot_strap_latch_monitor i_mon (.aclk, .aresetn, .chip_enable,
  .strap_pull_up_en, .strap_pull_down_en, .strap_pins_functional, .chip_active,
  .boot_from_flash, .boot_download, .boot_select_invalid, .boot_log_enable,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- tb.sv ----
// self-checking bench for the boot strap latch
`timescale 1ns/1ps
module tb;
  import strap_pkg::*;
  logic aclk, aresetn, chip_enable, strap_pins_functional, chip_active;
  logic flash_supply_1v8, boot_from_flash, boot_download, boot_select_invalid;
  logic boot_log_enable, sdio_sample_rising, sdio_output_rising;
  logic [STRAP_W-1:0] drive_en, drive_val, straps, strap_pull_up_en, strap_pull_down_en;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0] dec_seen;
  int n_errors, check_count;
  typedef struct {logic [4:0] en; logic [4:0] val; logic [4:0] cap;} row_t;
  // open pins, all low, all high, invalid boot, mixed, two of five driven
  row_t rows [6] = '{'{5'h00, 5'h00, 5'h1a}, '{5'h1f, 5'h00, 5'h00},
    '{5'h1f, 5'h1f, 5'h1f}, '{5'h1f, 5'h04, 5'h04}, '{5'h1f, 5'h09, 5'h09},
    '{5'h0a, 5'h00, 5'h10}};
  assign dec_seen = {sdio_output_rising, sdio_sample_rising, boot_log_enable,
    boot_select_invalid, boot_download, boot_from_flash, flash_supply_1v8};
  strap_board_model i_board (.aclk, .drive_en, .drive_val, .strap_pull_up_en,
    .strap_pull_down_en, .straps);
  boot_strap_latch i_dut (.aclk, .aresetn, .chip_enable, .supply_voltage_strap(straps[0]),
    .boot_select_strap(straps[1]), .download_qualify_strap(straps[2]),
    .log_and_timing_strap(straps[3]), .sdio_output_edge_strap(straps[4]),
    .strap_pull_up_en, .strap_pull_down_en, .strap_pins_functional, .chip_active,
    .flash_supply_1v8, .boot_from_flash, .boot_download, .boot_select_invalid,
    .boot_log_enable, .sdio_sample_rising, .sdio_output_rising, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [6:0] dec(input logic [4:0] c);
    return {c[4], c[3], c[3], ~c[1] & c[2], ~c[1] & ~c[2], c[1], c[0]};
  endfunction : dec
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic hang;
    n_errors++;
    tally_and_finish();
  endtask : hang
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 40) hang();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 40) hang();
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask : axr
  // hold long enough for the pin filter to settle before the last reset edge
  task automatic rst;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'({strap_pull_up_en, strap_pull_down_en}), {22'h0, PULL_UP_MASK, PULL_DOWN_MASK});
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : rst
  initial begin
    {aresetn, drive_en, drive_val, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
    chip_enable = 1'b1;
    n_errors = 0;
    check_count = 0;
    foreach (rows[i]) begin
      drive_en <= rows[i].en;
      drive_val <= rows[i].val;
      rst();
      chk(32'({strap_pull_up_en, strap_pull_down_en, strap_pins_functional, chip_active}),
          32'h3);
      chk(32'(dec_seen), 32'(dec(rows[i].cap)));
      axr(OFS_CAPTURE, 32'(rows[i].cap), 32'hffffffff, RESP_OKAY);
      axr(OFS_STATUS, {23'h0, 1'b0, 1'b1, dec(rows[i].cap)}, 32'h1ff, RESP_OKAY);
    end
    drive_en <= 5'h1f;
    drive_val <= 5'h05;
    repeat (8) @(posedge aclk);
    axr(OFS_CAPTURE, 32'h10, 32'hffffffff, RESP_OKAY);
    chk(32'(dec_seen), 32'(dec(5'h10)));
    axr(OFS_STATUS, 32'h100, 32'h100, RESP_OKAY);
    axw(OFS_OVERRIDE, 32'h0f, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(dec_seen), 32'h25);
    axw(OFS_OVERRIDE, 32'h00, 4'h2, RESP_OKAY);
    axr(OFS_OVERRIDE, 32'h0f, 32'hffffffff, RESP_OKAY);
    axw(OFS_CAPTURE, 32'h00, 4'hf, RESP_SLVERR);
    axr(OFS_CAPTURE, 32'h10, 32'hffffffff, RESP_OKAY);
    axr(4'hc, 32'h0, 32'hffffffff, RESP_DECERR);
    chip_enable <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'({chip_active, dec_seen}), 32'h0);
    chip_enable <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(32'(dec_seen), 32'(dec(5'h05)));
    axr(OFS_CAPTURE, 32'h05, 32'hffffffff, RESP_OKAY);
    axr(OFS_OVERRIDE, 32'h00, 32'hffffffff, RESP_OKAY);
    tally_and_finish();
  end
endmodule : tb
